/* hw/rcs_pkg.sv */
/*
  Constants and types of the reset and clock sequencer.
  Assumes a 200 MHz system clock and a synchronous active-low reset.
*/
package rcs_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ     = 200;
  localparam int T_OUT_NS    = 100;
  localparam int T_IN_NS     = 50;
  localparam int T_GLITCH_NS = 100;
  localparam logic [15:0] OUT_CYC    = 16'((T_OUT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] IN_CYC     = 16'((T_IN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] GLITCH_CYC = 16'((T_GLITCH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [9:0]  DELAY_SA   = 10'h200;
  localparam logic [9:0]  DELAY_USB  = 10'h100;
  localparam logic [1:0]  FETCH_CYC  = 2'h2;
  localparam logic [15:0] VEC_ADDR   = 16'hFFFE;

  // ****************************************
  // Clock derivation
  // ****************************************
  localparam int OSC_SA_MHZ  = 12;
  localparam int OSC_USB_MHZ = 48;
  localparam int F_SA_MHZ    = 6;
  localparam int F_USB_MHZ   = 8;
  localparam logic [7:0] HALF_SA  = 8'((CLK_MHZ + 2 * F_SA_MHZ - 1) / (2 * F_SA_MHZ));
  localparam logic [7:0] HALF_USB = 8'((CLK_MHZ + 2 * F_USB_MHZ - 1) / (2 * F_USB_MHZ));

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_MISC1  = 8'h00;
  localparam logic [7:0] ADDR_PWR    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int MISC1_CP_LSB = 0;
  localparam int MISC1_CPU_PRESCALE_ENABLE   = 2;
  localparam int PWR_PLUG_IRQ_ENABLE    = 0;
  localparam int ST_USB       = 0;
  localparam int ST_LVD       = 1;
  localparam int ST_CAUSE_LSB = 2;
  localparam logic [2:0] MISC1_RST = 3'h0;
  localparam logic       PWR_RST   = 1'b0;

  typedef enum logic [3:0] {
    PH_ACTIVE = 4'b0001,
    PH_DELAY  = 4'b0010,
    PH_FETCH  = 4'b0100,
    PH_RUN    = 4'b1000
  } rcs_phase_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcs_bus_type;

  typedef struct packed {
    logic [4:0]    s1;
    logic [4:0]    s2;
    logic [2:0]    oe_hist;
    logic [15:0]   ext_cnt;
    logic [15:0]   glitch_cnt;
    logic          low_voltage_detector;
    logic [15:0]   stretch;
    rcs_phase_type phase;
    logic [9:0]    dcnt;
    logic [1:0]    fcnt;
    logic          usb_mode;
    logic [7:0]    half_cnt;
    logic          cpu_clk;
    logic [2:0]    misc1;
    logic          plug_irq_enable;
    logic [2:0]    cause;
    logic [7:0]    rdata;
    logic [15:0]   vec_addr;
  } rcs_state_type;

  localparam rcs_state_type STATE_RST = '{
    s1: 5'h10, s2: 5'h10, oe_hist: 3'h7, ext_cnt: 16'h0000, glitch_cnt: 16'h0000,
    low_voltage_detector: 1'b0, stretch: 16'h0000, phase: PH_ACTIVE, dcnt: 10'h000, fcnt: 2'h0,
    usb_mode: 1'b0, half_cnt: 8'h00, cpu_clk: 1'b0, misc1: MISC1_RST, plug_irq_enable: PWR_RST,
    cause: 3'h0, rdata: 8'h00, vec_addr: VEC_ADDR};

endpackage

/* hw/rcs_sequencer.sv */
/*
  Reset sequencer and core clock selection: merges external, low-voltage and
  watchdog resets, drives the open-drain reset pin, runs delay and vector
  fetch, and divides the CPU clock.
  Assumes pins and analog comparator levels arrive asynchronously, the
  watchdog pulse is on clk_sys_i, and a plain register port on clk_sys_i.
*/
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// [RULE_01] Three sources merge; pin low during delay
// [RULE_02] Start address fetched from FFFEh-FFFFh
// [RULE_03] Phases: active, delay, then vector fetch
// [RULE_04] Stand-alone delay is 512 CPU cycles
// [RULE_05] USB delay 256 cycles after PLL lock
// [RULE_06] Vector fetch lasts exactly two cycles
// [RULE_07] Reset pin is input and open-drain output
// [RULE_08] External low pulse needs minimum width
// [RULE_09] External pulse stretched to minimum output width
// [RULE_10] Watchdog underflow drives pin minimum width
// [RULE_11] Low-voltage detect uses threshold hysteresis
// [RULE_12] Supply spikes shorter than filter ignored
// [RULE_13] Pin held low during low-voltage reset
// [RULE_14] Oscillator 12 MHz stand-alone, 48 MHz USB
// [RULE_15] Software prescale field selects CPU clock
// [RULE_16] USB supply: PLL on, CPU up to 8 MHz
// [RULE_17] Main supply: PLL off, CPU max 6 MHz
// [RULE_18] CPU clock is 50% square wave
// [RULE_19] Software keeps plug interrupt enable cleared
// [RULE_20] Unused supply switch pin may be I/O
// [RULE_21] Outside holds reset while device blank
// [RULE_22] USB mode reset drives supply switch low
// [RULE_23] Reset outside USB mode stops the PLL
// [RULE_24] New reset during delay restarts the count
module rcs_sequencer
  import rcs_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // Register port
  input  wire rcs_pkg::rcs_bus_type bus_i,
  output logic [7:0]                rdata_o,
  // Reset pin
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_o,
  // Reset sources
  input  wire logic                 wdg_underflow_i,
  input  wire logic                 below_rising_i,
  input  wire logic                 below_falling_i,
  // Supply and clocks
  input  wire logic                 usb_supply_i,
  input  wire logic                 pll_lock_i,
  input  wire logic                 switch_fn_opt_i,
  // Core side
  output logic                      core_reset_o,
  output logic                      vec_fetch_o,
  output logic [15:0]               vec_addr_o,
  output logic                      cpu_clk_o,
  output logic                      cpu_tick_o,
  output logic                      pll_en_o,
  output logic                      osc_fast_o,
  output logic                      supply_switch_o,
  output logic                      supply_switch_oe_o,
  output logic                      plug_irq_enable_o
);
  import rcs_pkg::*;

  // ****************************************
  // State and decode
  // ****************************************
  rcs_state_type st;
  rcs_state_type next_st;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic       pin_low;
  logic       quiet;
  logic       ext_hit;
  logic       lvd_raw;
  logic       src;
  logic       tick;
  logic       drive;
  logic [7:0] half;
  logic       lock;
  logic [9:0] target;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.s1 = {rst_pin_i, below_rising_i, below_falling_i, usb_supply_i, pll_lock_i};
    next_st.s2 = st.s1;
    pin_low = ~st.s2[4];
    lock = st.s2[0];
    quiet = (st.oe_hist == 3'h0);
    // External pulse recognition after minimum low width
    if (pin_low && quiet) begin  // see [RULE_08]
      if (st.ext_cnt != IN_CYC) begin
        next_st.ext_cnt = st.ext_cnt + 16'h0001;
      end
    end else begin
      next_st.ext_cnt = 16'h0000;
    end
    ext_hit = pin_low && quiet && (st.ext_cnt == IN_CYC - 16'h0001);
    // Hysteresis: compare against rising level while in reset, else falling
    lvd_raw = st.low_voltage_detector ? st.s2[3] : st.s2[2];  // see [RULE_11]
    if (lvd_raw != st.low_voltage_detector) begin  // see [RULE_12]
      next_st.glitch_cnt = st.glitch_cnt + 16'h0001;
      if (st.glitch_cnt == GLITCH_CYC - 16'h0001) begin
        next_st.low_voltage_detector = lvd_raw;
        next_st.glitch_cnt = 16'h0000;
      end
    end else begin
      next_st.glitch_cnt = 16'h0000;
    end
    // Output width stretch for external and watchdog resets
    if (ext_hit || wdg_underflow_i) begin  // see [RULE_09] see [RULE_10]
      next_st.stretch = OUT_CYC;
    end else if (st.stretch != 16'h0000) begin
      next_st.stretch = st.stretch - 16'h0001;
    end
    src = ext_hit || wdg_underflow_i || st.low_voltage_detector || (st.stretch != 16'h0000);  // see [RULE_01]
    // CPU clock divider
    half = (st.usb_mode ? HALF_USB : HALF_SA) << (st.misc1[MISC1_CPU_PRESCALE_ENABLE] ?  // see [RULE_15]
           st.misc1[MISC1_CP_LSB +: 2] : 2'h0);
    tick = 1'b0;
    if (st.half_cnt >= half - 8'h01) begin  // see [RULE_18]
      next_st.half_cnt = 8'h00;
      next_st.cpu_clk = ~st.cpu_clk;
      tick = ~st.cpu_clk;
    end else begin
      next_st.half_cnt = st.half_cnt + 8'h01;
    end
    target = st.usb_mode ? DELAY_USB : DELAY_SA;
    // Phase sequence
    if (src) begin  // see [RULE_24]
      next_st.phase = PH_ACTIVE;
      next_st.dcnt = 10'h000;
    end else begin
      unique case (st.phase)
        PH_ACTIVE: begin  // see [RULE_03]
          next_st.phase = PH_DELAY;
          next_st.dcnt = 10'h000;
          next_st.usb_mode = st.s2[1];  // see [RULE_23]
        end
        PH_DELAY: begin
          if (tick && (!st.usb_mode || lock)) begin  // see [RULE_04] see [RULE_05]
            next_st.dcnt = st.dcnt + 10'h001;
            if (st.dcnt == target - 10'h001) begin
              next_st.phase = PH_FETCH;
              next_st.fcnt = 2'h0;
              next_st.vec_addr = VEC_ADDR;
            end
          end
        end
        PH_FETCH: begin
          if (tick) begin  // see [RULE_06]
            next_st.fcnt = st.fcnt + 2'h1;
            next_st.vec_addr = VEC_ADDR + 16'h0001;  // see [RULE_02]
            if (st.fcnt == FETCH_CYC - 2'h1) begin
              next_st.phase = PH_RUN;
            end
          end
        end
        PH_RUN: begin
          next_st.phase = PH_RUN;
        end
      endcase
    end
    drive = (st.phase == PH_ACTIVE) || (st.phase == PH_DELAY);  // see [RULE_13]
    next_st.oe_hist = {st.oe_hist[1:0], drive};
    // Registers
    if (bus_i.wr && hit(bus_i.addr, ADDR_MISC1)) begin
      next_st.misc1 = bus_i.wdata[2:0];
    end
    if (bus_i.wr && hit(bus_i.addr, ADDR_PWR)) begin
      next_st.plug_irq_enable = bus_i.wdata[PWR_PLUG_IRQ_ENABLE];
    end
    if (bus_i.wr && hit(bus_i.addr, ADDR_STATUS)) begin
      next_st.cause = st.cause & ~bus_i.wdata[ST_CAUSE_LSB +: 3];
    end
    next_st.cause = next_st.cause | {wdg_underflow_i, st.low_voltage_detector, ext_hit};
    next_st.rdata = 8'h00;
    if (bus_i.rd) begin
      if (hit(bus_i.addr, ADDR_MISC1)) begin
        next_st.rdata = {5'h00, st.misc1};
      end else if (hit(bus_i.addr, ADDR_PWR)) begin
        next_st.rdata = {7'h00, st.plug_irq_enable};
      end else if (hit(bus_i.addr, ADDR_STATUS)) begin
        next_st.rdata = {3'h0, st.cause, st.low_voltage_detector, st.usb_mode};
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o            = st.rdata;
  assign rst_pin_o          = 1'b0;
  assign rst_pin_oe_o       = st.oe_hist[0];  // see [RULE_07]
  assign core_reset_o       = (st.phase != PH_RUN);
  assign vec_fetch_o        = (st.phase == PH_FETCH);
  assign vec_addr_o         = st.vec_addr;
  assign cpu_clk_o          = st.cpu_clk;
  assign cpu_tick_o         = tick;
  assign pll_en_o           = st.usb_mode;  // see [RULE_16] see [RULE_17]
  assign osc_fast_o         = st.usb_mode;  // see [RULE_14]
  assign supply_switch_o    = 1'b0;
  assign supply_switch_oe_o = st.usb_mode && switch_fn_opt_i;  // see [RULE_22] see [RULE_20]
  assign plug_irq_enable_o  = st.plug_irq_enable;  // see [RULE_19]

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_delay_pin_low: assert property (st.phase == PH_DELAY |=> rst_pin_oe_o)  // see [RULE_01]
    else $error("Reset pin released during delay");
  a_vector_first: assert property ($rose(vec_fetch_o) |-> vec_addr_o == 16'hFFFE)  // see [RULE_02]
    else $error("Vector fetch did not start at FFFE");
  a_fetch_end: assert property (st.phase == PH_FETCH && tick && st.fcnt == 2'h1 && !src  // see [RULE_06]
    |=> st.phase == PH_RUN && vec_addr_o == 16'hFFFF)
    else $error("Vector fetch length wrong");
  a_sa_delay_len: assert property (st.phase == PH_DELAY && !st.usb_mode && tick  // see [RULE_04]
    && st.dcnt == 10'h1FF && !src |=> st.phase == PH_FETCH)
    else $error("Stand-alone delay not 512");
  a_usb_lock_wait: assert property (st.phase == PH_DELAY && st.usb_mode && !lock && !src  // see [RULE_05]
    |=> $stable(st.dcnt))
    else $error("USB delay counted before lock");
  a_wdg_stretch: assert property (wdg_underflow_i |=> ##1 rst_pin_oe_o [*8])  // see [RULE_10]
    else $error("Watchdog reset pin width short");
  a_lvd_hold: assert property (st.low_voltage_detector |=> ##1 rst_pin_oe_o && core_reset_o)  // see [RULE_13]
    else $error("Pin not low during low-voltage reset");
  a_restart_delay: assert property (st.phase != PH_ACTIVE && wdg_underflow_i  // see [RULE_24]
    |=> st.phase == PH_ACTIVE ##1 st.dcnt == 10'h000)
    else $error("Reset during delay did not restart");
  a_switch_mode: assert property (supply_switch_oe_o |-> pll_en_o && switch_fn_opt_i)  // see [RULE_22]
    else $error("Supply switch driven outside USB mode");

  // ****************************************
  // Reset source checks
  // ****************************************
  a_ext_stretch: assert property (ext_hit  // see [RULE_09]
    |=> ##1 rst_pin_oe_o [*8])
    else $error("External reset not stretched");
  a_ext_width: assert property (ext_hit  // see [RULE_08]
    |-> $past(pin_low, 9))
    else $error("External reset taken before minimum width");
  a_ext_cause: assert property (ext_hit  // see [RULE_08]
    |=> st.cause[0])
    else $error("External reset cause not recorded");
  a_wdg_cause: assert property (wdg_underflow_i  // see [RULE_10]
    |=> st.cause[2])
    else $error("Watchdog reset cause not recorded");
  a_lvd_cause: assert property (st.low_voltage_detector  // see [RULE_13]
    |=> st.cause[1])
    else $error("Low-voltage reset cause not recorded");
  a_glitch_filter: assert property (st.low_voltage_detector != next_st.low_voltage_detector  // see [RULE_12]
    |-> st.glitch_cnt == GLITCH_CYC - 16'h0001)
    else $error("Low-voltage state changed before filter time");
  a_lvd_rise_leave: assert property (st.low_voltage_detector && !st.s2[3]  // see [RULE_11]
    && st.glitch_cnt == GLITCH_CYC - 16'h0001 |=> !st.low_voltage_detector)
    else $error("Low-voltage reset not left above rising level");
  a_lvd_fall_enter: assert property (!st.low_voltage_detector && st.s2[2]  // see [RULE_11]
    && st.glitch_cnt == GLITCH_CYC - 16'h0001 |=> st.low_voltage_detector)
    else $error("Low-voltage reset not entered below falling level");
  a_lvd_keep: assert property (st.low_voltage_detector && st.s2[3]  // see [RULE_11]
    |=> st.low_voltage_detector)
    else $error("Low-voltage reset left below rising level");
  a_src_active: assert property (src  // see [RULE_01]
    |=> st.phase == PH_ACTIVE && core_reset_o)
    else $error("Reset source did not enter active phase");

  // ****************************************
  // Phase checks
  // ****************************************
  a_active_next: assert property (st.phase == PH_ACTIVE && !src  // see [RULE_03]
    |=> st.phase == PH_DELAY && st.dcnt == 10'h000)
    else $error("Active phase not followed by delay");
  a_delay_next: assert property (st.phase == PH_DELAY && !src  // see [RULE_03]
    |=> st.phase inside {PH_DELAY, PH_FETCH})
    else $error("Delay phase left out of order");
  a_fetch_next: assert property (st.phase == PH_FETCH && !src  // see [RULE_03]
    |=> st.phase inside {PH_FETCH, PH_RUN})
    else $error("Fetch phase left out of order");
  a_usb_delay_len: assert property (st.phase == PH_DELAY && st.usb_mode && tick && lock  // see [RULE_05]
    && st.dcnt == 10'h0FF && !src |=> st.phase == PH_FETCH)
    else $error("USB delay not 256");
  a_usb_delay_early: assert property (st.phase == PH_DELAY && st.usb_mode  // see [RULE_05]
    && st.dcnt < 10'h0FF && !src |=> st.phase == PH_DELAY)
    else $error("USB delay ended early");
  a_sa_delay_early: assert property (st.phase == PH_DELAY && !st.usb_mode  // see [RULE_04]
    && st.dcnt < 10'h1FF && !src |=> st.phase == PH_DELAY)
    else $error("Stand-alone delay ended early");
  a_fetch_first: assert property (st.phase == PH_FETCH && tick && st.fcnt == 2'h0 && !src  // see [RULE_06]
    |=> st.phase == PH_FETCH && vec_addr_o == 16'hFFFF)
    else $error("Vector fetch second cycle wrong");
  a_fetch_hold: assert property (st.phase == PH_FETCH && !tick && !src  // see [RULE_06]
    |=> $stable(st.fcnt) && vec_fetch_o)
    else $error("Vector fetch advanced without a CPU cycle");
  a_pin_release: assert property (st.phase == PH_FETCH && !src  // see [RULE_07]
    |=> ##1 !rst_pin_oe_o)
    else $error("Reset pin still driven after delay");

  // ****************************************
  // Clock and register checks
  // ****************************************
  a_clock_steady: assert property (st.half_cnt < half - 8'h01  // see [RULE_18]
    |=> $stable(cpu_clk_o))
    else $error("CPU clock toggled before half period");
  a_sa_max_rate: assert property (!st.usb_mode  // see [RULE_17]
    |-> half >= HALF_SA)
    else $error("Stand-alone CPU clock too fast");
  a_usb_max_rate: assert property (st.usb_mode  // see [RULE_16]
    |-> half >= HALF_USB)
    else $error("USB mode CPU clock too fast");
  a_mode_latch: assert property (st.phase == PH_ACTIVE && !src  // see [RULE_23]
    |=> pll_en_o == $past(st.s2[1]))
    else $error("Supply mode not taken at end of active phase");
  a_mode_kept: assert property (st.phase != PH_ACTIVE || src  // see [RULE_23]
    |=> $stable(pll_en_o))
    else $error("Supply mode changed outside reset");
  a_prescale_write: assert property (bus_i.wr && hit(bus_i.addr, ADDR_MISC1)  // see [RULE_15]
    |=> st.misc1 == $past(bus_i.wdata[2:0]))
    else $error("Prescale write not taken");
  a_read_idle: assert property (!bus_i.rd  // see [RULE_15]
    |=> rdata_o == 8'h00)
    else $error("Read data present without a read");
  a_switch_on: assert property (pll_en_o && switch_fn_opt_i  // see [RULE_22]
    |-> supply_switch_oe_o)
    else $error("Supply switch not driven in USB mode");

endmodule // rcs_sequencer

/* verification/rcs_board.sv */
/*
  Board model: reset line with weak pull-up, USB supply and PLL lock.
  Assumes the bench requests external pulls and supply changes.
*/
`timescale 1ns/10ps
module rcs_board
(
  // Clock
  input  wire logic clk_sys_i,
  // Bench requests
  input  wire logic ext_pull_i,
  input  wire logic usb_on_i,
  // Device side
  input  wire logic dev_oe_i,
  input  wire logic pll_en_i,
  output logic      rst_pin_o,
  output logic      usb_supply_o,
  output logic      pll_lock_o
);
  int lock_cnt = 0;
  // ****************************************
  // Wired reset line, pulled up when released
  // ****************************************
  assign rst_pin_o    = ~(ext_pull_i | dev_oe_i);
  assign usb_supply_o = usb_on_i;
  // ****************************************
  // PLL locks some time after enable
  // ****************************************
  always @(posedge clk_sys_i) begin
    lock_cnt <= (usb_on_i && pll_en_i) ? lock_cnt + 1 : 0;
  end
  assign pll_lock_o = lock_cnt > 100;
endmodule // rcs_board

/* verification/reset_and_clock_sequencer_tb.sv */
/*
  Self-checking bench of the reset and clock sequencer.
  Assumes a 200 MHz clock and the board model on the reset pin.
*/
`timescale 1ns/10ps
module reset_and_clock_sequencer_tb;
  import rcs_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [7:0] p;} rcs_row_type;
  logic clk_sys_i, nrst_i, pull, usb_on, pin, wdg, br, bf, opt, usb_sup, lock;
  rcs_bus_type bus;
  logic [7:0]  rdata_o;
  logic [15:0] vec_addr_o, va0, va1;
  logic oe, core_reset_o, vec_fetch_o, cpu_clk_o, cpu_tick_o, pll_en_o, osc_fast_o, sw_oe;
  logic pie, pin_d, sw_d;
  localparam int P_WDG = 0, P_PULL = 1, P_BR = 2;
  int miscompares = 0, tests_run = 0, n, ln, fc, p, h;
  logic [7:0] r;
  rcs_row_type rows [8] = '{'{8'h08, 8'hff, 8'h00, 8'h00}, '{8'h0c, 8'hff, 8'h00, 8'h00},
    '{8'h04, 8'h01, 8'h01, 8'h00}, '{8'h04, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h04, 8'h04, 8'd34},
    '{8'h00, 8'h05, 8'h05, 8'd68}, '{8'h00, 8'h03, 8'h03, 8'd34}, '{8'h00, 8'h00, 8'h00, 8'd34}};
  rcs_sequencer i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus_i(bus), .rdata_o(rdata_o),
    .rst_pin_i(pin), .rst_pin_o(pin_d), .rst_pin_oe_o(oe), .wdg_underflow_i(wdg), .below_rising_i(br),
    .below_falling_i(bf), .usb_supply_i(usb_sup), .pll_lock_i(lock), .switch_fn_opt_i(opt),
    .core_reset_o(core_reset_o), .vec_fetch_o(vec_fetch_o), .vec_addr_o(vec_addr_o),
    .cpu_clk_o(cpu_clk_o), .cpu_tick_o(cpu_tick_o), .pll_en_o(pll_en_o), .osc_fast_o(osc_fast_o),
    .supply_switch_o(sw_d), .supply_switch_oe_o(sw_oe), .plug_irq_enable_o(pie));
  rcs_board i_board (.clk_sys_i(clk_sys_i), .ext_pull_i(pull), .usb_on_i(usb_on), .dev_oe_i(oe),
    .pll_en_i(pll_en_o), .rst_pin_o(pin), .usb_supply_o(usb_sup), .pll_lock_o(lock));
  // ****************************************
  // Helpers
  // ****************************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i) bus <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i) bus <= '0;
    #1 d = rdata_o;
  endtask
  task pulse(input int which, input int k);
    @(posedge clk_sys_i);
    case (which)
      P_WDG:   wdg <= 1'b1;
      P_PULL:  pull <= 1'b1;
      default: br <= 1'b1;
    endcase
    repeat (k) @(posedge clk_sys_i);
    case (which)
      P_WDG:   wdg <= 1'b0;
      P_PULL:  pull <= 1'b0;
      default: br <= 1'b0;
    endcase
  endtask
  task boot;
    int k;
    n = 0; ln = 0; k = 0; fc = 0; va0 = '0; va1 = '0;
    do begin
      cyc(1);
      k++;
      if (cpu_tick_o && oe) begin
        n++;
        ln += lock;
      end
      if (vec_fetch_o) begin
        if (fc == 0 && va0 === 16'h0000) va0 = vec_addr_o;
        va1 = vec_addr_o;
        fc += cpu_tick_o;
      end
    end while (core_reset_o || k < 4);
    check(va0, 16'hfffe);
    check(va1, 16'hffff);
    check(16'(fc), 16'd2);
    check(oe, 1'b0);
  endtask
  task per;
    p = 0; h = 0;
    while (!cpu_tick_o) cyc(1);
    do begin
      cyc(1);
      p++;
      h += cpu_clk_o;
    end while (!cpu_tick_o);
  endtask
  task cause(input logic [7:0] e);
    rd(ADDR_STATUS, r);
    check(r, e);
    wr(ADDR_STATUS, 8'hff);
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    nrst_i = 1'b0; bus = '0; pull = 1'b0; usb_on = 1'b0; wdg = 1'b0; br = 1'b0; bf = 1'b0; opt = 1'b1;
    cyc(8);
    nrst_i <= 1'b1;
    boot();
    check(16'(n >= 512 && n <= 514), 16'd1);
    check({pll_en_o, osc_fast_o}, 2'b00);
    check({pin_d, sw_d}, 2'b00);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      check(r, rows[i].e);
      if (rows[i].a == ADDR_PWR) check(pie, rows[i].e[0]);
      if (rows[i].p != 0) begin
        per();
        check(16'(p), 16'(rows[i].p));
        check(16'(h * 2), 16'(p));
      end
    end
    $display("test standalone boot and registers done");
    usb_on <= 1'b1;
    pulse(P_WDG, 1);
    boot();
    check(16'(ln >= 256 && ln <= 258), 16'd1);
    check({pll_en_o, osc_fast_o, sw_oe}, 3'b111);
    per();
    check(16'(p), 16'd26);
    opt <= 1'b0;
    cyc(3);
    check(sw_oe, 1'b0);
    opt <= 1'b1;
    cause(8'h11);
    $display("test usb boot done");
    pulse(P_PULL, 4);
    cyc(30);
    check(core_reset_o, 1'b0);
    pulse(P_PULL, 15);
    boot();
    check(16'(ln >= 256 && ln <= 258), 16'd1);
    cause(8'h05);
    $display("test external pulse done");
    pulse(P_WDG, 1);
    cyc(3000);
    pulse(P_WDG, 1);
    boot();
    check(16'(ln >= 256 && ln <= 258), 16'd1);
    cause(8'h11);
    $display("test watchdog restart done");
    bf <= 1'b1; br <= 1'b1;
    cyc(10);
    bf <= 1'b0; br <= 1'b0;
    cyc(30);
    check(core_reset_o, 1'b0);
    pulse(P_BR, 40);
    cyc(3);
    check(core_reset_o, 1'b0);
    bf <= 1'b1; br <= 1'b1;
    cyc(40);
    check(oe, 1'b1);
    bf <= 1'b0;
    cyc(40);
    check(oe, 1'b1);
    br <= 1'b0;
    boot();
    cause(8'h09);
    $display("test low voltage done");
    usb_on <= 1'b0;
    pulse(P_WDG, 1);
    boot();
    check(16'(n >= 512 && n <= 514), 16'd1);
    check({pll_en_o, osc_fast_o, sw_oe}, 3'b000);
    $display("test leave usb done");
    stop_test();
  end
endmodule // reset_and_clock_sequencer_tb
